/* File: src/lc_cfg.svh */
`ifndef LC_CFG_SVH
`define LC_CFG_SVH

// register bus widths
`define LC_ADR_W        8
`define LC_DAT_W        32
`define LC_SEL_W        4

// register byte addresses
`define LC_ADR_CTRL     8'h00
`define LC_ADR_MASK     8'h04
`define LC_ADR_STAT     8'h08

// control register fields
`define LC_CTRL_W       5
`define LC_CTRL_ARITH   0
`define LC_CTRL_INDEP   1
`define LC_CTRL_CHAIN   2
`define LC_CTRL_SLD_INV 3
`define LC_CTRL_SCL_INV 4
`define LC_CTRL_RST     5'h00

// table mask layout
`define LC_MASK_W       16
`define LC_HALF_W       8
`define LC_MASK_RST     16'h0000

// status register fields
`define LC_STAT_REG     0
`define LC_STAT_LUT     1
`define LC_STAT_ARITH   2

// register output after reset
`define LC_REG_RST      1'h0

`endif

/* File: src/lc_pkg.sv */
package lc_pkg;

  // table operating mode
  typedef enum logic
  {
    LC_NORMAL,
    LC_ARITH
  } lc_mode_t;

  // source of the register's normal data path
  typedef enum logic
  {
    LC_SRC_LUT,
    LC_SRC_INDEP
  } lc_src_t;

endpackage : lc_pkg

/* File: src/lc_lut4.sv */
`include "lc_cfg.svh"

module lc_lut4
  import lc_pkg::*;
(
  input  wire logic [`LC_MASK_W-1:0] mask_i,     // table contents
  input  wire lc_mode_t              mode_i,     // normal or split table
  input  wire logic [3:0]            data_i,     // {d, c, b, a}
  input  wire logic                  carry_in_i, // from the cell below in chain
  output logic                       sum_o,      // function output
  output logic                       carry_o     // carry towards next cell
);

  logic [3:0] idx4; // normal mode index
  logic [2:0] idx3; // half-table index

  // table lookup, output is the mask bit picked by the inputs
  always_comb
  begin
    idx4 = data_i;
    idx3 = {carry_in_i, data_i[1:0]};
    if (mode_i == LC_ARITH)
    begin
      // lower half gives the sum, upper half the carry
      sum_o   = mask_i[{1'b0, idx3}];
      carry_o = mask_i[{1'b1, idx3}];
    end
    else
    begin
      // whole table is one four-input function
      sum_o   = mask_i[idx4];
      carry_o = 1'b0;
    end
  end

endmodule : lc_lut4

/* File: src/lc_cell_reg.sv */
`include "lc_cfg.svh"

module lc_cell_reg
  import lc_pkg::*;
(
  input  wire logic clk_i,        // core clock
  input  wire logic rst_i,        // async reset, active high
  input  wire logic path_d_i,     // selected normal data path
  input  wire logic chain_en_i,   // cascade mode on
  input  wire logic chain_in_i,   // cascade input from cell above
  input  wire logic sload_i,      // effective synchronous load
  input  wire logic sclr_i,       // effective synchronous clear
  input  wire logic sload_data_i, // data stored on load
  output logic      q_o           // register output
);

  logic q_d; // next register value
  logic q_q; // register state

  // next value: clear, then load, then cascade, then data path
  always_comb
  begin
    if (sclr_i)
      q_d = 1'b0;
    else if (sload_i)
      q_d = sload_data_i;
    else if (chain_en_i)
      q_d = chain_in_i;
    else
      q_d = path_d_i;
  end

  // storage, changes on the clock edge or on async reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      q_q <= `LC_REG_RST;
    else
      q_q <= q_d;
  end

  assign q_o = q_q;

endmodule : lc_cell_reg

/* File: src/lc_cell_top.sv */
`include "lc_cfg.svh"

module lc_cell_top
  import lc_pkg::*;
(
  input  wire logic                 CORE_CLK_I,        // core clock
  input  wire logic                 RST_I,             // async reset
  input  wire logic [`LC_ADR_W-1:0] ADR_I,             // bus address
  input  wire logic [`LC_DAT_W-1:0] DAT_I,             // bus write data
  input  wire logic [`LC_SEL_W-1:0] SEL_I,             // byte enables
  input  wire logic                 WE_I,              // write request
  input  wire logic                 CYC_I,             // bus cycle
  input  wire logic                 STB_I,             // bus strobe
  output logic      [`LC_DAT_W-1:0] DAT_O,             // bus read data
  output logic                      ACK_O,             // bus acknowledge
  input  wire logic                 DATA_A_I,          // table input a
  input  wire logic                 DATA_B_I,          // table input b
  input  wire logic                 DATA_C_I,          // table input c
  input  wire logic                 DATA_D_I,          // table input d
  input  wire logic                 CARRY_IN_PORT_I,   // chain carry in
  input  wire logic                 INDEP_FUNC_I,      // other cell's function
  input  wire logic                 REG_CHAIN_IN_I,    // cascade from above
  input  wire logic                 SYNC_LOAD_I,       // synchronous load
  input  wire logic                 SYNC_CLEAR_I,      // synchronous clear
  input  wire logic                 SYNC_LOAD_DATA_I,  // data for load
  output logic                      LUT_OUT_O,         // function output
  output logic                      CARRY_OUT_PORT_O,  // chain carry out
  output logic                      REGISTER_OUTPUT_O  // register output
);

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  logic [`LC_CTRL_W-1:0] ctrl_q;  // control register
  logic [`LC_CTRL_W-1:0] ctrl_d;  // its next value
  logic [`LC_MASK_W-1:0] mask_q;  // table mask register
  logic [`LC_MASK_W-1:0] mask_d;  // its next value
  logic                  ack_q;   // acknowledge flop
  logic                  ack_d;   // its next value
  logic [`LC_DAT_W-1:0]  dat_q;   // read data flop
  logic [`LC_DAT_W-1:0]  dat_d;   // its next value

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  lc_mode_t mode;       // table mode
  lc_src_t  src;        // register data source
  logic     chain_en;   // cascade mode
  logic     sload_inv;  // load control inverted
  logic     sclr_inv;   // clear control inverted
  logic     sload_eff;  // load after inversion
  logic     sclr_eff;   // clear after inversion
  logic     lut_sum;    // table function output
  logic     lut_carry;  // table carry output
  logic     path_d;     // selected normal data path
  logic     reg_q;      // register state
  logic     bus_req;    // request pending, not yet answered
  logic     bus_wr;     // write taking effect this edge

  // control fields to typed values
  always_comb
  begin
    mode      = ctrl_q[`LC_CTRL_ARITH] ? LC_ARITH : LC_NORMAL;
    src       = ctrl_q[`LC_CTRL_INDEP] ? LC_SRC_INDEP : LC_SRC_LUT;
    chain_en  = ctrl_q[`LC_CTRL_CHAIN];
    sload_inv = ctrl_q[`LC_CTRL_SLD_INV];
    sclr_inv  = ctrl_q[`LC_CTRL_SCL_INV];
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------

  // request seen, answered one cycle later
  assign bus_req = CYC_I & STB_I & ~ack_q;

  // write lands on the edge where the master sees ack
  assign bus_wr = CYC_I & STB_I & WE_I & ack_q;

  // next values of bus and configuration state
  always_comb
  begin
    ack_d  = bus_req;
    dat_d  = '0;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    // read data captured with the acknowledge
    if (bus_req && !WE_I)
    begin
      case (ADR_I)
        `LC_ADR_CTRL:
          dat_d[`LC_CTRL_W-1:0] = ctrl_q;
        `LC_ADR_MASK:
          dat_d[`LC_MASK_W-1:0] = mask_q;
        `LC_ADR_STAT:
        begin
          // carry stays off the status word, it feeds only the chain
          dat_d[`LC_STAT_REG]   = reg_q;
          dat_d[`LC_STAT_LUT]   = lut_sum;
          dat_d[`LC_STAT_ARITH] = ctrl_q[`LC_CTRL_ARITH];
        end
        default:
          dat_d = '0; // unmapped reads as zero
      endcase
    end
    // writes honour byte enables
    if (bus_wr)
    begin
      case (ADR_I)
        `LC_ADR_CTRL:
        begin
          if (SEL_I[0])
            ctrl_d = DAT_I[`LC_CTRL_W-1:0];
        end
        `LC_ADR_MASK:
        begin
          // low byte is sum half in arithmetic mode
          if (SEL_I[0])
            mask_d[`LC_HALF_W-1:0] = DAT_I[`LC_HALF_W-1:0];
          // high byte is carry half in arithmetic mode
          if (SEL_I[1])
            mask_d[`LC_MASK_W-1:`LC_HALF_W] = DAT_I[`LC_MASK_W-1:`LC_HALF_W];
        end
        default:
          ctrl_d = ctrl_q; // status and unmapped ignore writes
      endcase
    end
  end

  // bus and configuration flops
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ack_q  <= 1'b0;
      dat_q  <= '0;
      ctrl_q <= `LC_CTRL_RST;
      mask_q <= `LC_MASK_RST;
    end
    else
    begin
      ack_q  <= ack_d;
      dat_q  <= dat_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  // ---------------------------------------------------------------
  // lookup table
  // ---------------------------------------------------------------

  // mask bit picked by the inputs, split in arithmetic mode
  lc_lut4 u_lut
  (
    .mask_i     (mask_q),
    .mode_i     (mode),
    .data_i     ({DATA_D_I, DATA_C_I, DATA_B_I, DATA_A_I}),
    .carry_in_i (CARRY_IN_PORT_I),
    .sum_o      (lut_sum),
    .carry_o    (lut_carry)
  );

  // function output to routing
  assign LUT_OUT_O = lut_sum;

  // carry goes only to the chain port, never to routing
  assign CARRY_OUT_PORT_O = lut_carry;

  // ---------------------------------------------------------------
  // register path
  // ---------------------------------------------------------------

  // data path select and control inversion
  always_comb
  begin
    // table output or another cell's function
    path_d = (src == LC_SRC_INDEP) ? INDEP_FUNC_I : lut_sum;
    // per-cell inversion of the load and clear nets that the fabric shares across the group
    // one load and one clear net per group, each cell applies its own inversion from its control register
    sload_eff = SYNC_LOAD_I ^ sload_inv;
    sclr_eff  = SYNC_CLEAR_I ^ sclr_inv;
  end

  // the cell's register with clear, load and cascade
  lc_cell_reg u_reg
  (
    .clk_i        (CORE_CLK_I),
    .rst_i        (RST_I),
    .path_d_i     (path_d),
    .chain_en_i   (chain_en),
    .chain_in_i   (REG_CHAIN_IN_I),
    .sload_i      (sload_eff),
    .sclr_i       (sclr_eff),
    .sload_data_i (SYNC_LOAD_DATA_I),
    .q_o          (reg_q)
  );

  assign REGISTER_OUTPUT_O = reg_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  // active clear empties the register on the next edge
  AST_CLEAR_WINS: assert property (
    sclr_eff |=> !REGISTER_OUTPUT_O)
    else $error("clear did not empty the register");

  // an edge with reset still high stores nothing, so paths are checked off reset
  // load without clear stores the load data
  AST_LOAD_DATA: assert property (
    !RST_I && sload_eff && !sclr_eff
    |=> REGISTER_OUTPUT_O == $past(SYNC_LOAD_DATA_I))
    else $error("load did not store load data");

  // inverted load control loads on a low input
  AST_LOAD_INVERTED: assert property (
    !RST_I && sload_inv && !SYNC_LOAD_I && !sclr_eff
    |=> REGISTER_OUTPUT_O == $past(SYNC_LOAD_DATA_I))
    else $error("inverted load not honoured");

  // cascade feeds the register when no control is active
  AST_CHAIN_PATH: assert property (
    !RST_I && chain_en && !sload_eff && !sclr_eff
    |=> REGISTER_OUTPUT_O == $past(REG_CHAIN_IN_I))
    else $error("cascade input not stored");

  // independent function reaches the register
  AST_INDEP_PATH: assert property (
    !RST_I && src == LC_SRC_INDEP && !chain_en && !sload_eff && !sclr_eff
    |=> REGISTER_OUTPUT_O == $past(INDEP_FUNC_I))
    else $error("independent function not stored");

  // table output reaches the register
  AST_LUT_PATH: assert property (
    !RST_I && src == LC_SRC_LUT && !chain_en && !sload_eff && !sclr_eff
    |=> REGISTER_OUTPUT_O == $past(LUT_OUT_O))
    else $error("table output not stored");

  // normal mode drives no carry
  AST_NORMAL_NO_CARRY: assert property (
    mode == LC_NORMAL |-> !CARRY_OUT_PORT_O)
    else $error("carry driven in normal mode");

  // arithmetic sum uses only the lower half
  AST_ARITH_SUM: assert property (
    mode == LC_ARITH
    |-> LUT_OUT_O == mask_q[{1'b0, CARRY_IN_PORT_I, DATA_B_I, DATA_A_I}])
    else $error("sum half lookup wrong");

  // arithmetic carry uses only the upper half
  AST_ARITH_CARRY: assert property (
    mode == LC_ARITH
    |-> CARRY_OUT_PORT_O == mask_q[{1'b1, CARRY_IN_PORT_I, DATA_B_I, DATA_A_I}])
    else $error("carry half lookup wrong");

  // full mask write shows on the table one edge later
  AST_MASK_WRITE: assert property (
    bus_wr && ADR_I == `LC_ADR_MASK && SEL_I[1:0] == 2'h3
    |=> mask_q == $past(DAT_I[`LC_MASK_W-1:0]))
    else $error("mask write lost");

  // every request gets a one-cycle acknowledge
  AST_BUS_ACK: assert property (
    bus_req |=> ACK_O ##1 !ACK_O)
    else $error("acknowledge not a single pulse");

  // normal mode picks the mask bit by all four inputs
  AST_NORMAL_SUM: assert property (
    mode == LC_NORMAL
    |-> LUT_OUT_O == mask_q[{DATA_D_I, DATA_C_I, DATA_B_I, DATA_A_I}])
    else $error("four-input lookup wrong");

  // inverted clear empties the register on a low input
  AST_CLEAR_INVERTED: assert property (
    sclr_inv && !SYNC_CLEAR_I |=> !REGISTER_OUTPUT_O)
    else $error("inverted clear not honoured");

  // control write through lane zero lands on the ack edge
  AST_CTRL_WRITE: assert property (
    bus_wr && ADR_I == `LC_ADR_CTRL && SEL_I[0]
    |=> ctrl_q == $past(DAT_I[`LC_CTRL_W-1:0]))
    else $error("control write lost");

  // sum half written alone leaves the carry half untouched
  AST_MASK_LOW_LANE: assert property (
    bus_wr && ADR_I == `LC_ADR_MASK && SEL_I[1:0] == 2'h1
    |=> mask_q[`LC_HALF_W-1:0] == $past(DAT_I[`LC_HALF_W-1:0])
    && $stable(mask_q[`LC_MASK_W-1:`LC_HALF_W]))
    else $error("mask lane write wrong");

  // status is read only, a write changes no configuration
  AST_STAT_NO_WRITE: assert property (
    bus_wr && ADR_I == `LC_ADR_STAT |=> $stable(ctrl_q) && $stable(mask_q))
    else $error("status write changed configuration");

  // status shows register and table output of the request edge
  AST_STAT_READ: assert property (
    bus_req && !WE_I && ADR_I == `LC_ADR_STAT
    |=> DAT_O[`LC_STAT_REG] == $past(reg_q)
    && DAT_O[`LC_STAT_LUT] == $past(lut_sum))
    else $error("status read wrong");

  // status bits above the arithmetic flag read as zero
  AST_STAT_UPPER_ZERO: assert property (
    bus_req && !WE_I && ADR_I == `LC_ADR_STAT
    |=> DAT_O[`LC_DAT_W-1:`LC_STAT_ARITH+1] == '0)
    else $error("status upper bits not zero");

  // unmapped addresses read as zero
  AST_UNMAPPED_READ_ZERO: assert property (
    bus_req && !WE_I && ADR_I != `LC_ADR_CTRL
    && ADR_I != `LC_ADR_MASK && ADR_I != `LC_ADR_STAT
    |=> DAT_O == '0)
    else $error("unmapped read not zero");

  // read data is zero outside the acknowledge cycle
  AST_DAT_IDLE_ZERO: assert property (
    !ACK_O |-> DAT_O == '0)
    else $error("read data not zero while idle");

  // scenarios worth seeing
  COV_CLEAR_AND_LOAD: cover property (sclr_eff && sload_eff);
  COV_ARITH_CARRY:    cover property (mode == LC_ARITH && CARRY_OUT_PORT_O);
  COV_CHAIN_SHIFT:    cover property (chain_en && REG_CHAIN_IN_I ##1 REGISTER_OUTPUT_O);
  COV_BUS_WRITE:      cover property (bus_wr && ADR_I == `LC_ADR_CTRL);
  COV_CLEAR_INVERTED: cover property (sclr_inv && !SYNC_CLEAR_I);

endmodule : lc_cell_top

/* File: bench/lc_nbr_model.sv */
module lc_nbr_model
(
  input  wire logic       clk_i,   // fabric clock
  input  wire logic       rst_i,   // async reset
  input  wire logic [2:0] pick_i,  // neighbour values from bench
  output logic            chain_o, // register of cell above
  output logic            func_o,  // other cell's function
  output logic            carry_o  // carry of cell below
);
  timeunit 1ns;
  timeprecision 1ps;

  // neighbour registers step on the shared clock
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chain_o <= 1'h0;
      func_o  <= 1'h0;
    end
    else
    begin
      chain_o <= pick_i[0]; // only the cell directly above
      func_o  <= pick_i[1];
    end
  end

  // carry leaves the cell below combinationally
  assign carry_o = pick_i[2];
endmodule : lc_nbr_model

/* File: bench/testbench.sv */
`include "lc_cfg.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, we, cyc, stb, ack;  // clock, reset, bus control
  logic [7:0]  adr;                          // bus address
  logic [31:0] dat, rd, r;                   // write, read, taken data
  logic [3:0]  sel, din;                     // lanes, table inputs
  logic [2:0]  pick;                         // neighbour choice
  logic        ld, cl, sd, lut, carry_out_port, q;     // cell pins
  logic        chain, func, carry;           // neighbour outputs
  logic [4:0]  ctl;                          // expected control
  logic [15:0] msk;                          // expected mask
  logic        eq;                           // expected register
  int          seed, fails, n_checks;        // random state, counters

  lc_cell_top dut
  (
    .CORE_CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat),
    .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb),
    .DAT_O(rd), .ACK_O(ack), .DATA_A_I(din[0]), .DATA_B_I(din[1]),
    .DATA_C_I(din[2]), .DATA_D_I(din[3]), .CARRY_IN_PORT_I(carry),
    .INDEP_FUNC_I(func), .REG_CHAIN_IN_I(chain), .SYNC_LOAD_I(ld),
    .SYNC_CLEAR_I(cl), .SYNC_LOAD_DATA_I(sd), .LUT_OUT_O(lut),
    .CARRY_OUT_PORT_O(carry_out_port), .REGISTER_OUTPUT_O(q)
  );

  lc_nbr_model nbr
  (
    .clk_i(clk), .rst_i(rst), .pick_i(pick),
    .chain_o(chain), .func_o(func), .carry_o(carry)
  );

  // free running core clock
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one classic bus cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= a;
    dat <= d;
    sel <= s;
    do
      @(posedge clk);
    while (ack !== 1'h1);
    r = rd;
    {cyc, stb, we} <= 3'h0;
  endtask : wb

  // expected {table out, carry, next register}
  function automatic logic [2:0] pred();
    logic [3:0] ix;
    logic       f, cy, ld_e, cl_e;
    ix   = ctl[0] ? {1'h0, carry, din[1:0]} : din;
    f    = msk[ix];
    cy   = ctl[0] & msk[{1'h1, ix[2:0]}];
    ld_e = ld ^ ctl[3];
    cl_e = cl ^ ctl[4];
    return {f, cy, cl_e ? 1'h0 : ld_e ? sd : ctl[2] ? chain : ctl[1] ? func : f};
  endfunction : pred

  // one random fabric cycle
  task automatic step(input logic skip);
    logic [2:0] e;
    @(posedge clk);
    din  <= 4'($random(seed));
    pick <= 3'($random(seed));
    {ld, cl, sd} <= 3'($random(seed)); // one shared load and clear
    @(negedge clk);
    e = pred();
    chk("lut_out", 32'(lut), 32'(e[2]));
    chk("carry_out", 32'(carry_out_port), 32'(e[1]));
    if (!skip) chk("reg_out", 32'(q), 32'(eq));
    eq = e[0];
  endtask : step

  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // watchdog against a hang
  initial
  begin
    #400000;
    fails++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    seed = 32'h675F;
    {rst, cyc, stb, we, ld, cl, sd} = 7'h40;
    {adr, dat, sel, din, pick} = '0;
    {ctl, msk, eq} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    // reset values and map corners
    chk("reg_rst", 32'(q), 32'h0);
    wb(1'h0, `LC_ADR_MASK, 32'h0, 4'hF);
    chk("mask_rst", r, 32'h0);
    wb(1'h1, `LC_ADR_MASK, 32'hFFFF_A55A, 4'h1);
    wb(1'h0, `LC_ADR_MASK, 32'h0, 4'hF);
    chk("mask_lane", r, 32'h0000_005A);
    wb(1'h1, `LC_ADR_STAT, 32'hFFFF_FFFF, 4'hF);
    wb(1'h0, 8'h0C, 32'h0, 4'hF);
    chk("unmapped", r, 32'h0);
    wb(1'h1, `LC_ADR_CTRL, 32'hFFFF_FFE0, 4'hF);
    wb(1'h0, `LC_ADR_CTRL, 32'h0, 4'hF);
    chk("ctrl_bits", r, 32'h0);
    $display("test regs done");
    // every mode, source and inversion
    for (int k = 0; k < 32; k++)
    begin
      ctl = 5'(k);
      msk = (k == 31) ? 16'h8001 : 16'($random(seed));
      wb(1'h1, `LC_ADR_CTRL, 32'(ctl), 4'h1);
      wb(1'h1, `LC_ADR_MASK, 32'(msk), 4'h3);
      wb(1'h0, `LC_ADR_CTRL, 32'h0, 4'hF);
      chk("ctrl", r, 32'(ctl));
      wb(1'h0, `LC_ADR_STAT, 32'h0, 4'hF);
      chk("stat_arith", r & 32'h4, 32'(ctl[0]) << 2);
      step(1'h1);
      repeat (40) step(1'h0);
    end
    $display("test modes done");
    // reset again in mid-run
    @(posedge clk);
    {rst, ld, cl, sd} <= 4'h8;
    @(negedge clk);
    chk("reg_mid_rst", 32'(q), 32'h0);
    @(posedge clk);
    rst <= 1'h0;
    {ctl, msk} = '0;
    wb(1'h0, `LC_ADR_CTRL, 32'h0, 4'hF);
    chk("ctrl_mid_rst", r, 32'h0);
    wb(1'h0, `LC_ADR_STAT, 32'h0, 4'hF);
    chk("stat_mid_rst", r, 32'h0);
    step(1'h1);
    repeat (20) step(1'h0);
    $display("test rerst done");
    print_verdict();
  end
endmodule : testbench
